// File: rtl/cmp_event_pkg.sv
// constants and types for the comparator event control block
// assumes an axi4-lite master and a comparator output synchronous-or-async to I_MCLK
// Operation
// - keep comparing in shallow stop
// - output pin follows result in stop
// - stop event sets flag, wakes if enabled
// - reset exit restores all reset values
// - deep stop: powered down, reset state
// - runs in wait, enabled event wakes
// - debug halt changes nothing
// - routing bit feeds timer capture zero
// - selectable rising, falling, any edge
// - bandgap select replaces positive input
// - result visible on output pin
// - 00/10 fall, 01 rise, 11 both
// - flag cleared only by writing one
// - live result bit, zero when disabled
// - irq high while flag and enable
package cmp_event_pkg;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] SYSOPT_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
  localparam logic [11:0] IRQ_CLEAR_OFFSET = 12'h00C;
  localparam logic [11:0] IRQ_ENABLE_OFFSET = 12'h010;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_BGSEL_BIT = 6;
  localparam int CTRL_FLAG_BIT = 5;
  localparam int CTRL_IRQEN_BIT = 4;
  localparam int CTRL_LIVE_BIT = 3;
  localparam int CTRL_OPE_BIT = 2;
  localparam int SYSOPT_ROUTE_BIT = 0;
  localparam int STAT_RISE_BIT = 0;
  localparam int STAT_FALL_BIT = 1;
  localparam logic [1:0] EDGE_RESET = 2'h0;
  localparam logic [1:0] EDGE_FALL0 = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RDATA = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic enable;
    logic bandgap_sel;
    logic compare_event_flag;
    logic compare_irq_enable;
    logic output_pin_enable;
    logic [1:0] event_edge_select;
    logic capture_route_select;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
  } ctrl_regs_t;

  // edge decode used by the core and by its assertions
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      2'h0, 2'h2: hit = fall;
      2'h1: hit = rise;
      default: hit = rise | fall;
    endcase
    return hit;
  endfunction : edge_hit
endpackage : cmp_event_pkg

// File: rtl/cmp_sync.sv
// two-flop synchroniser for the comparator result
// assumes the input may change at any time relative to the clock
`timescale 1ns/1ps
module cmp_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_sync
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next.meta = i_async;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.stable;
endmodule : cmp_sync

// File: rtl/cmp_edge.sv
// edge detector on the synchronised comparator result
// assumes its input is already synchronous; disable forces history low
`timescale 1ns/1ps
module cmp_edge (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_enable,
  input wire logic i_level,
  output logic o_rise,
  output logic o_fall,
  output logic o_level
);
  typedef struct packed {
    logic prev;
  } edge_state_t;
  edge_state_t st_reg;
  edge_state_t st_next;

  always_comb begin
    st_next.prev = i_enable ? i_level : 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // enabling with a high result counts as a rising edge; history starts at zero
  assign o_rise = i_enable & i_level & ~st_reg.prev;
  assign o_fall = i_enable & ~i_level & st_reg.prev;
  assign o_level = st_reg.prev;
endmodule : cmp_edge

// File: rtl/cmp_event_ctrl.sv
// comparator event control: axi4-lite registers, flag, irq, wake, pin routing
// assumes one clock; system reset also covers exit from stop by reset and deep stop
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cmp_event_ctrl
  import cmp_event_pkg::*;
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SRST,
  // axi4-lite slave
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [11:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // analog core and timer pin
  input wire logic I_CMP_RESULT,
  input wire logic I_TIMER_PIN_IN,
  // to analog core
  output logic O_ANALOG_ENABLE,
  output logic O_BANDGAP_SEL,
  // to pins, timer and processor
  output logic O_COMPARATOR_OUT_PIN,
  output logic O_COMPARATOR_OUT_OE_N,
  output logic O_TIMER_CAPTURE_IN,
  output logic O_IRQ,
  output logic O_WAKE,
  output logic O_STATUS_IRQ
);
  typedef struct packed {
    bus_state_t bus;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] resp;
    logic [31:0] rdata;
    ctrl_regs_t regs;
    logic live;
    logic pin;
    logic pin_oe_n;
    logic cap;
    logic irq;
    logic wake;
    logic stat_irq;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic sync_level;
  logic rise;
  logic fall;
  logic level;
  logic hit;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] ctrl_word;

  cmp_sync u_sync (
    .i_clk(I_MCLK),
    .i_srst(I_SRST),
    .i_async(I_CMP_RESULT),
    .o_sync(sync_level)
  );

  // no stop or wait input: the block simply never changes with processor mode
  cmp_edge u_edge (
    .i_clk(I_MCLK),
    .i_srst(I_SRST),
    .i_enable(st_reg.regs.enable),
    .i_level(sync_level),
    .o_rise(rise),
    .o_fall(fall),
    .o_level(level)
  );

  always_comb begin
    hit = edge_hit(st_reg.regs.event_edge_select, rise, fall);
    ctrl_word = {st_reg.regs.enable, st_reg.regs.bandgap_sel, st_reg.regs.compare_event_flag,
                 st_reg.regs.compare_irq_enable, st_reg.live, st_reg.regs.output_pin_enable,
                 st_reg.regs.event_edge_select};
    wr_fire = (st_reg.bus == BUS_IDLE) && st_reg.aw_got && st_reg.w_got;
    rd_fire = (st_reg.bus == BUS_IDLE) && I_ARVALID && !wr_fire;
  end

  always_comb begin
    st_next = st_reg;
    // write address and data accepted in either order
    if (st_reg.bus == BUS_IDLE && !st_reg.aw_got && I_AWVALID) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = I_AWADDR;
    end
    if (st_reg.bus == BUS_IDLE && !st_reg.w_got && I_WVALID) begin
      st_next.w_got = 1'b1;
      st_next.wdata = I_WDATA;
      st_next.wstrb = I_WSTRB;
    end
    // hardware sets: set wins over a same-cycle clear
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bus = BUS_WRESP;
      st_next.resp = RESP_OKAY;
      unique case (st_reg.awaddr)
        CTRL_OFFSET: begin
          if (st_reg.wstrb[0]) begin
            st_next.regs.enable = st_reg.wdata[CTRL_ENABLE_BIT];
            st_next.regs.bandgap_sel = st_reg.wdata[CTRL_BGSEL_BIT];
            st_next.regs.compare_irq_enable = st_reg.wdata[CTRL_IRQEN_BIT];
            st_next.regs.output_pin_enable = st_reg.wdata[CTRL_OPE_BIT];
            st_next.regs.event_edge_select = st_reg.wdata[1:0];
            if (st_reg.wdata[CTRL_FLAG_BIT]) begin
              st_next.regs.compare_event_flag = 1'b0;
            end
          end
        end
        SYSOPT_OFFSET: begin
          if (st_reg.wstrb[0]) begin
            st_next.regs.capture_route_select = st_reg.wdata[SYSOPT_ROUTE_BIT];
          end
        end
        IRQ_CLEAR_OFFSET: begin
          if (st_reg.wstrb[0]) begin
            st_next.regs.irq_status = st_reg.regs.irq_status & ~st_reg.wdata[1:0];
          end
        end
        IRQ_ENABLE_OFFSET: begin
          if (st_reg.wstrb[0]) begin
            st_next.regs.irq_enable = st_reg.wdata[1:0];
          end
        end
        IRQ_STATUS_OFFSET: st_next.resp = RESP_OKAY;
        default: st_next.resp = RESP_SLVERR;
      endcase
    end else if (rd_fire) begin
      st_next.bus = BUS_RDATA;
      st_next.resp = RESP_OKAY;
      unique case (I_ARADDR)
        CTRL_OFFSET: st_next.rdata = {24'h00_0000, ctrl_word};
        SYSOPT_OFFSET: st_next.rdata = {31'h0000_0000, st_reg.regs.capture_route_select};
        IRQ_STATUS_OFFSET: st_next.rdata = {30'h0000_0000, st_reg.regs.irq_status};
        IRQ_ENABLE_OFFSET: st_next.rdata = {30'h0000_0000, st_reg.regs.irq_enable};
        IRQ_CLEAR_OFFSET: st_next.rdata = 32'h0000_0000;
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.resp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bus == BUS_WRESP && I_BREADY) begin
      st_next.bus = BUS_IDLE;
    end
    if (st_reg.bus == BUS_RDATA && I_RREADY) begin
      st_next.bus = BUS_IDLE;
    end
    // events keep running in wait, stop and debug alike
    if (hit) begin
      st_next.regs.compare_event_flag = 1'b1;
    end
    if (rise) begin
      st_next.regs.irq_status[STAT_RISE_BIT] = 1'b1;
    end
    if (fall) begin
      st_next.regs.irq_status[STAT_FALL_BIT] = 1'b1;
    end
    st_next.live = st_reg.regs.enable & level;
    st_next.pin = st_next.live;
    st_next.pin_oe_n = ~(st_next.regs.enable & st_next.regs.output_pin_enable);
    // route picks comparator over the timer pin regardless of timer setup
    st_next.cap = st_next.regs.capture_route_select ? st_next.live : I_TIMER_PIN_IN;
    st_next.irq = st_next.regs.compare_event_flag & st_next.regs.compare_irq_enable;
    st_next.wake = st_next.irq;
    st_next.stat_irq = |(st_next.regs.irq_status & st_next.regs.irq_enable);
    // handshake levels are registered so every port leaves a flop
    st_next.awready = (st_next.bus == BUS_IDLE) && !st_next.aw_got;
    st_next.wready = (st_next.bus == BUS_IDLE) && !st_next.w_got;
    st_next.arready = (st_next.bus == BUS_IDLE) && !(st_next.aw_got && st_next.w_got);
    st_next.bvalid = st_next.bus == BUS_WRESP;
    st_next.rvalid = st_next.bus == BUS_RDATA;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      st_reg <= '0;
      st_reg.bus <= BUS_IDLE;
      st_reg.pin_oe_n <= 1'b1;
      st_reg.regs.event_edge_select <= EDGE_RESET;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_AWREADY = st_reg.awready;
  assign O_WREADY = st_reg.wready;
  assign O_BVALID = st_reg.bvalid;
  assign O_BRESP = st_reg.resp;
  assign O_ARREADY = st_reg.arready;
  assign O_RVALID = st_reg.rvalid;
  assign O_RDATA = st_reg.rdata;
  assign O_RRESP = st_reg.resp;
  assign O_ANALOG_ENABLE = st_reg.regs.enable;
  assign O_BANDGAP_SEL = st_reg.regs.bandgap_sel;
  assign O_COMPARATOR_OUT_PIN = st_reg.pin;
  assign O_COMPARATOR_OUT_OE_N = st_reg.pin_oe_n;
  assign O_TIMER_CAPTURE_IN = st_reg.cap;
  assign O_IRQ = st_reg.irq;
  assign O_WAKE = st_reg.wake;
  assign O_STATUS_IRQ = st_reg.stat_irq;

  a_flag_on_event: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    hit |=> st_reg.regs.compare_event_flag) else $error("event did not set flag");
  a_flag_sticky: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.compare_event_flag && !(wr_fire && st_reg.awaddr == CTRL_OFFSET)
    |=> st_reg.regs.compare_event_flag) else $error("flag dropped without write");
  a_irq_follows: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.compare_event_flag && st_reg.regs.compare_irq_enable |-> O_IRQ)
    else $error("irq missing");
  a_live_off: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !st_reg.regs.enable |=> !st_reg.live) else $error("live bit set while disabled");
  a_route_cap: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.capture_route_select |-> O_TIMER_CAPTURE_IN == st_reg.live)
    else $error("capture not routed");
  a_pin_drive: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.enable && st_reg.regs.output_pin_enable |-> !O_COMPARATOR_OUT_OE_N)
    else $error("pin not driven");
  a_wake_event: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    hit && st_reg.regs.compare_irq_enable && !wr_fire |=> O_WAKE)
    else $error("no wake on event");
  a_rise_only: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.event_edge_select == EDGE_RISE && fall && !rise && !st_reg.regs.compare_event_flag
    |=> !st_reg.regs.compare_event_flag) else $error("fall set rise-mode flag");
  a_reset_state: assert property (@(posedge I_MCLK)
    I_SRST |=> !st_reg.regs.enable && !st_reg.regs.compare_event_flag && !O_IRQ)
    else $error("reset state wrong");

  // bus answers stand until taken and come in the stated cycle
  a_bvalid_hold: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped early");

  a_rvalid_hold: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
    else $error("read data dropped early");

  a_write_answer: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_AWREADY && I_AWVALID && O_WREADY && I_WVALID |=> ##1 O_BVALID)
    else $error("write response late");

  a_read_answer: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_ARREADY && I_ARVALID |=> O_RVALID)
    else $error("read data late");

  a_busy_quiet: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_BVALID || O_RVALID |-> !O_AWREADY && !O_WREADY && !O_ARREADY)
    else $error("ready while answering");

  a_wr_unmapped: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    wr_fire && st_reg.awaddr > IRQ_ENABLE_OFFSET |=> O_BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");

  a_rd_unmapped: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_ARREADY && I_ARVALID && I_ARADDR > IRQ_ENABLE_OFFSET
    |=> O_RRESP == RESP_SLVERR && O_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

  // events, flag and status bits
  a_events_gated: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !st_reg.regs.enable |-> !rise && !fall)
    else $error("edge seen while disabled");

  a_flag_needs_enable: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !st_reg.regs.enable && !st_reg.regs.compare_event_flag
    |=> !st_reg.regs.compare_event_flag)
    else $error("flag set while disabled");

  a_fall_only: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.event_edge_select == EDGE_FALL0 && rise && !st_reg.regs.compare_event_flag
    |=> !st_reg.regs.compare_event_flag) else $error("rise set fall-mode flag");

  a_flag_clear: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    wr_fire && st_reg.awaddr == CTRL_OFFSET && st_reg.wstrb[0] && st_reg.wdata[CTRL_FLAG_BIT]
    && !hit |=> !st_reg.regs.compare_event_flag)
    else $error("write one did not clear flag");

  a_status_rise: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    rise |=> st_reg.regs.irq_status[STAT_RISE_BIT])
    else $error("rise status not set");

  a_status_fall: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    fall |=> st_reg.regs.irq_status[STAT_FALL_BIT])
    else $error("fall status not set");

  a_status_sticky: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.irq_status[STAT_FALL_BIT] && !(wr_fire && st_reg.awaddr == IRQ_CLEAR_OFFSET)
    |=> st_reg.regs.irq_status[STAT_FALL_BIT]) else $error("status dropped without clear");

  a_status_clear: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    wr_fire && st_reg.awaddr == IRQ_CLEAR_OFFSET && st_reg.wstrb[0]
    && st_reg.wdata[STAT_RISE_BIT] && !rise |=> !st_reg.regs.irq_status[STAT_RISE_BIT])
    else $error("status clear ignored");

  // outputs follow their register bits
  a_oe_off: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !st_reg.regs.output_pin_enable |-> O_COMPARATOR_OUT_OE_N)
    else $error("pin driven without pin enable");

  a_irq_quiet: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !st_reg.regs.compare_irq_enable |-> !O_IRQ && !O_WAKE)
    else $error("irq without irq enable");

  a_stat_irq: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (st_reg.regs.irq_status & st_reg.regs.irq_enable) != 2'h0 |-> O_STATUS_IRQ)
    else $error("status irq missing");

  a_route_off: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !st_reg.regs.capture_route_select && !$past(I_SRST)
    |-> O_TIMER_CAPTURE_IN == $past(I_TIMER_PIN_IN))
    else $error("timer pin not passed through");

  a_reset_outputs: assert property (@(posedge I_MCLK)
    I_SRST |=> O_COMPARATOR_OUT_OE_N && !O_WAKE && !O_STATUS_IRQ && !O_BVALID && !O_RVALID
    && O_AWREADY && O_WREADY && O_ARREADY)
    else $error("outputs not at reset values");
  c_rise: cover property (@(posedge I_MCLK) disable iff (I_SRST) rise && hit);
  c_both: cover property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.event_edge_select == EDGE_BOTH && fall);
  c_wake: cover property (@(posedge I_MCLK) disable iff (I_SRST) O_WAKE);
  c_fall0: cover property (@(posedge I_MCLK) disable iff (I_SRST)
    st_reg.regs.event_edge_select == EDGE_FALL0 && hit);
  c_status: cover property (@(posedge I_MCLK) disable iff (I_SRST) O_STATUS_IRQ);
endmodule : cmp_event_ctrl

// File: tb/cmp_analog_model.sv
// behavioural analog comparator core facing the event block
// assumes the bench sets the input levels; output is junk while unpowered
`timescale 1ns/1ps
module cmp_analog_model (
  // clock
  input wire logic i_clk,
  // control from the block and the power manager
  input wire logic i_enable,
  input wire logic i_bandgap_sel,
  input wire logic i_bgbuf_en,
  // levels against the minus input
  input wire logic i_plus_high,
  input wire logic i_bg_high,
  // result
  output logic o_result
);
  logic junk_reg = 1'b0;
  // an unpowered core has no steady level, so the block must not trust it
  always @(posedge i_clk) begin
    junk_reg <= ~junk_reg;
  end
  // reference only valid with its buffer on
  assign o_result = !i_enable ? junk_reg :
    (i_bandgap_sel ? (i_bgbuf_en ? i_bg_high : junk_reg) : i_plus_high);
endmodule : cmp_analog_model

// File: tb/test_comparator_event_control.sv
// self-checking bench for the comparator event control block
// assumes the analog model on the far side; power modes need no stimulus
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module test_comparator_event_control;
  import cmp_event_pkg::*;
  logic clk, srst, awv, wv, bry, arv, rry, plus, bg, bgbuf, tpin;
  logic awr, wrdy, bv, arr, rv, aen, bsel, opin, oen, cap, irq, wake, sirq, res;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, rd_d;
  logic [3:0] wst;
  logic [1:0] resp, brsp, rrsp;
  int error_cnt, num_checks;
  cmp_event_ctrl dut (.I_MCLK(clk), .I_SRST(srst), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(wst),
    .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(brsp), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rd_d), .O_RRESP(rrsp),
    .I_CMP_RESULT(res), .I_TIMER_PIN_IN(tpin), .O_ANALOG_ENABLE(aen), .O_BANDGAP_SEL(bsel),
    .O_COMPARATOR_OUT_PIN(opin), .O_COMPARATOR_OUT_OE_N(oen), .O_TIMER_CAPTURE_IN(cap),
    .O_IRQ(irq), .O_WAKE(wake), .O_STATUS_IRQ(sirq));
  cmp_analog_model core (.i_clk(clk), .i_enable(aen), .i_bandgap_sel(bsel),
    .i_bgbuf_en(bgbuf), .i_plus_high(plus), .i_bg_high(bg), .o_result(res));

  task automatic wrr(input logic [11:0] a, input logic [31:0] d);
    logic ga, gw, gb;
    ga = 0;
    gw = 0;
    gb = 0;
    @(posedge clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    bry <= 1;
    while (!gb) begin
      @(posedge clk);
      if (!ga && awr) begin
        ga = 1;
        awv <= 0;
      end
      if (!gw && wrdy) begin
        gw = 1;
        wv <= 0;
      end
      if (bv === 1'b1) begin
        gb = 1;
        resp = brsp;
        bry <= 0;
      end
    end
  endtask : wrr

  task automatic rdd(input logic [11:0] a);
    logic ga;
    ga = 0;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rry <= 1;
    while (rv !== 1'b1) begin
      @(posedge clk);
      if (!ga && arr) begin
        ga = 1;
        arv <= 0;
      end
    end
    rdat = rd_d;
    resp = rrsp;
    rry <= 0;
  endtask : rdd

  // settle time: synchroniser, edge detect, flag and irq flops
  task automatic w8();
    repeat (8) @(posedge clk);
  endtask : w8

  task automatic t_reset();
    logic [11:0] offs [4];
    offs = '{CTRL_OFFSET, SYSOPT_OFFSET, IRQ_STATUS_OFFSET, IRQ_ENABLE_OFFSET};
    foreach (offs[i]) begin
      rdd(offs[i]);
      `CHK(rdat, 32'h0000_0000, "reset value")
      `CHK(resp, RESP_OKAY, "reset read resp")
    end
    `CHK(oen, 1'b1, "pin released at reset")
    rdd(12'h020);
    `CHK(resp, RESP_SLVERR, "unmapped read")
    `CHK(rdat, 32'h0000_0000, "unmapped data")
    wrr(12'h020, 32'h0000_00FF);
    `CHK(resp, RESP_SLVERR, "unmapped write")
    wst <= 4'h0;
    wrr(CTRL_OFFSET, 32'h0000_0080);
    wst <= 4'h1;
    rdd(CTRL_OFFSET);
    `CHK(rdat, 32'h0000_0000, "write without lane 0")
  endtask : t_reset

  task automatic t_edges();
    logic [7:0] c;
    for (int m = 0; m < 4; m++) begin
      c = 8'h90 | 8'(m);
      plus <= 0;
      wrr(CTRL_OFFSET, {24'h0, c});
      w8();
      // enabling may latch a spurious edge from the unpowered core
      wrr(CTRL_OFFSET, {24'h0, c | 8'h20});
      plus <= 1;
      w8();
      rdd(CTRL_OFFSET);
      `CHK(rdat[CTRL_FLAG_BIT], m[0], "rise flag")
      `CHK(irq, m[0], "irq level")
      `CHK(wake, m[0], "wake level")
      wrr(CTRL_OFFSET, {24'h0, c});
      rdd(CTRL_OFFSET);
      `CHK(rdat[CTRL_FLAG_BIT], m[0], "write zero keeps flag")
      wrr(CTRL_OFFSET, {24'h0, c | 8'h20});
      plus <= 0;
      w8();
      rdd(CTRL_OFFSET);
      `CHK(rdat[CTRL_FLAG_BIT], m != 1, "fall flag")
    end
  endtask : t_edges

  task automatic t_pin();
    wrr(CTRL_OFFSET, 32'h0000_0084);
    plus <= 1;
    w8();
    rdd(CTRL_OFFSET);
    `CHK(rdat[CTRL_LIVE_BIT], 1'b1, "live result")
    `CHK(opin, 1'b1, "pin high")
    `CHK(oen, 1'b0, "pin driven")
    `CHK(aen, 1'b1, "core powered")
    wrr(CTRL_OFFSET, 32'h0000_0000);
    rdd(CTRL_OFFSET);
    `CHK(rdat[CTRL_LIVE_BIT], 1'b0, "live zero when off")
    `CHK(oen, 1'b1, "pin released")
    `CHK(aen, 1'b0, "core off")
    bgbuf <= 1;
    bg <= 1;
    plus <= 0;
    wrr(CTRL_OFFSET, 32'h0000_00C0);
    w8();
    rdd(CTRL_OFFSET);
    `CHK(bsel, 1'b1, "bandgap select")
    `CHK(rdat[CTRL_LIVE_BIT], 1'b1, "bandgap result")
  endtask : t_pin

  task automatic t_route();
    wrr(SYSOPT_OFFSET, 32'h0000_0001);
    wrr(CTRL_OFFSET, 32'h0000_0080);
    tpin <= 0;
    plus <= 1;
    w8();
    `CHK(cap, 1'b1, "capture follows result")
    plus <= 0;
    tpin <= 1;
    w8();
    `CHK(cap, 1'b0, "timer pin cut off")
    wrr(SYSOPT_OFFSET, 32'h0000_0000);
    w8();
    `CHK(cap, 1'b1, "timer pin restored")
  endtask : t_route

  task automatic t_irqregs();
    wrr(IRQ_CLEAR_OFFSET, 32'h0000_0003);
    wrr(IRQ_ENABLE_OFFSET, 32'h0000_0001);
    plus <= 1;
    w8();
    rdd(IRQ_STATUS_OFFSET);
    `CHK(rdat[STAT_RISE_BIT], 1'b1, "rise status")
    `CHK(sirq, 1'b1, "status irq")
    wrr(IRQ_ENABLE_OFFSET, 32'h0000_0000);
    rdd(IRQ_STATUS_OFFSET);
    `CHK(sirq, 1'b0, "status irq masked")
    wrr(IRQ_ENABLE_OFFSET, 32'h0000_0001);
    wrr(IRQ_CLEAR_OFFSET, 32'h0000_0001);
    rdd(IRQ_STATUS_OFFSET);
    `CHK(rdat[STAT_RISE_BIT], 1'b0, "status cleared")
    `CHK(sirq, 1'b0, "status irq gone")
  endtask : t_irqregs

  task automatic t_midreset();
    plus <= 0;
    wrr(CTRL_OFFSET, 32'h0000_0097);
    plus <= 1;
    w8();
    `CHK(irq, 1'b1, "irq before reset")
    srst <= 1;
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    `CHK(irq, 1'b0, "irq after reset")
    `CHK(oen, 1'b1, "pin after reset")
    rdd(CTRL_OFFSET);
    `CHK(rdat, 32'h0000_0000, "ctrl after reset")
  endtask : t_midreset

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {srst, awv, wv, bry, arv, rry} = 6'b100000;
    {plus, bg, bgbuf, tpin} = 4'h0;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0000_0000;
    wst = 4'h1;
    repeat (3) @(posedge clk);
    srst <= 0;
    t_reset();
    t_edges();
    t_pin();
    t_route();
    t_irqregs();
    t_midreset();
    tally_and_finish();
  end
endmodule : test_comparator_event_control
